// >>> core/pef_event_counters.sv
// event flag, enable and clear-on-read error counter register bank behind an apb slave
//
// Function
// RQ1: undervoltage event sets flag bit 15, held pending until cleared.
// RQ2: overvoltage event sets flag bit 14, held pending until cleared.
// RQ3: overtemperature event sets flag bit 11, held pending until cleared.
// RQ4: sleep mode event sets flag bit 10, held pending until cleared.
// RQ5: receive polarity change sets flag bit 9, held pending until cleared.
// RQ6: jabber detection sets flag bit 8, held pending until cleared.
// RQ7: writable enables 7,6,3,2,1,0 gate the six events; all reset to zero.
// RQ8: bits 13:12 and 5:4 of second flags register read zero.
// RQ9: eight-bit false carrier counter in bits 7:0; upper bits read zero.
// RQ10: false carrier counter saturates at its maximum instead of wrapping.
// RQ11: false carrier count above half-full raises an event.
// RQ12: reading false carrier count returns it and clears it.
// RQ13: sixteen-bit counter counts invalid symbols seen with carrier and data valid.
// RQ14: receive error counter holds while mac side loopback is on.
// RQ15: receive error counter saturates at all ones.
// RQ16: receive error count above half-full raises an event.
// RQ17: reading receive error count returns it and clears it.
// RQ18: half-full events flag bits 9,8 of first register, gated by enables 1,0.
// RQ19: latched flags clear on register read unless their event persists.
// RQ20: interrupt requested while any pending flag has its enable set.
// RQ21: host reads status and counters to acknowledge; reads destroy their contents.
`timescale 1ns/10ps
`default_nettype none
module pef_event_counters (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pef_pkg::ADDR_W-1:0] paddr,
    input wire logic [pef_pkg::DATA_W-1:0] pwdata,
    output logic [pef_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // asynchronous sensor and line levels
    input wire logic undervoltage,
    input wire logic overvoltage,
    input wire logic overtemperature,
    input wire logic sleep_event,
    input wire logic rx_polarity,
    input wire logic jabber,
    // receive path strobes on pclk
    input wire logic false_carrier,
    input wire logic rx_carrier,
    input wire logic rx_dv,
    input wire logic rx_invalid_symbol,
    input wire logic mac_side_interface_loopback,
    // interrupt request
    output logic int_req
);

    logic [pef_pkg::EVT_W-1:0] level_r;
    logic pol_prev_r;
    logic [pef_pkg::EVT_W-1:0] ev_now;
    logic [pef_pkg::EVT_W-1:0] flags_two_r;
    logic [pef_pkg::EVT_W-1:0] en_two_r;
    logic [1:0] hf_r;
    logic [1:0] en_one_r;
    logic [1:0] hf_now;
    logic [7:0] fc_cnt_r;
    logic [15:0] re_cnt_r;
    logic [7:0] fc_base;
    logic [15:0] re_base;
    logic [15:0] fc_next16;
    logic [15:0] re_next16;
    logic fc_inc;
    logic re_inc;
    logic [pef_pkg::DATA_W-1:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic int_req_r;
    logic setup;
    logic done;
    logic hit_one;
    logic hit_two;
    logic hit_fc;
    logic hit_re;
    logic rd_one;
    logic rd_two;
    logic rd_fc;
    logic rd_re;
    logic [15:0] rd_word;

    // sensor levels come from another domain
    pef_pin_sync #(
        .WIDTH(pef_pkg::EVT_W)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({undervoltage, overvoltage, overtemperature, sleep_event, rx_polarity, jabber}),
        .level_r(level_r)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pol_prev_r <= 1'b0;
        end else begin
            pol_prev_r <= level_r[pef_pkg::EV_POL];
        end
    end

    // polarity is a level; only its change is an event
    always_comb begin
        ev_now = level_r;
        ev_now[pef_pkg::EV_POL] = level_r[pef_pkg::EV_POL] ^ pol_prev_r; // [RQ5]
    end

    // apb decode; address must match a whole aligned word
    assign setup = psel && !penable;
    assign done = psel && penable && pready_r;
    assign hit_one = (paddr == pef_pkg::byte_addr(pef_pkg::IDX_FLAGS_ONE));
    assign hit_two = (paddr == pef_pkg::byte_addr(pef_pkg::IDX_FLAGS_TWO));
    assign hit_fc = (paddr == pef_pkg::byte_addr(pef_pkg::IDX_FC_CNT));
    assign hit_re = (paddr == pef_pkg::byte_addr(pef_pkg::IDX_RX_ERR_CNT));
    assign rd_one = done && !pwrite && hit_one;
    assign rd_two = done && !pwrite && hit_two;
    assign rd_fc = done && !pwrite && hit_fc;
    assign rd_re = done && !pwrite && hit_re;

    // read word assembled from live state; reserved bits stay zero
    always_comb begin
        rd_word = pef_pkg::REG_RESET; // [RQ8]
        if (hit_two) begin
            rd_word[pef_pkg::FLG_UV] = flags_two_r[pef_pkg::EV_UV]; // [RQ1]
            rd_word[pef_pkg::FLG_OV] = flags_two_r[pef_pkg::EV_OV]; // [RQ2]
            rd_word[pef_pkg::FLG_OT] = flags_two_r[pef_pkg::EV_OT]; // [RQ3]
            rd_word[pef_pkg::FLG_SLEEP] = flags_two_r[pef_pkg::EV_SLEEP]; // [RQ4]
            rd_word[pef_pkg::FLG_POL] = flags_two_r[pef_pkg::EV_POL]; // [RQ5]
            rd_word[pef_pkg::FLG_JAB] = flags_two_r[pef_pkg::EV_JAB]; // [RQ6]
            rd_word[pef_pkg::ENB_UV] = en_two_r[pef_pkg::EV_UV]; // [RQ7]
            rd_word[pef_pkg::ENB_OV] = en_two_r[pef_pkg::EV_OV];
            rd_word[pef_pkg::ENB_OT] = en_two_r[pef_pkg::EV_OT];
            rd_word[pef_pkg::ENB_SLEEP] = en_two_r[pef_pkg::EV_SLEEP];
            rd_word[pef_pkg::ENB_POL] = en_two_r[pef_pkg::EV_POL];
            rd_word[pef_pkg::ENB_JAB] = en_two_r[pef_pkg::EV_JAB];
        end else if (hit_one) begin
            rd_word[pef_pkg::FLG_FC_HF] = hf_r[1]; // [RQ18]
            rd_word[pef_pkg::FLG_RE_HF] = hf_r[0];
            rd_word[pef_pkg::ENB_FC_HF] = en_one_r[1];
            rd_word[pef_pkg::ENB_RE_HF] = en_one_r[0];
        end else if (hit_fc) begin
            rd_word[7:0] = fc_cnt_r; // [RQ9]
        end else if (hit_re) begin
            rd_word = re_cnt_r;
        end
    end

    // one access cycle after setup; data snapshot taken at the setup edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup && !(hit_one || hit_two || hit_fc || hit_re);
            if (setup && !pwrite) begin
                prdata_r <= {16'h0000, rd_word};
            end else if (setup) begin
                prdata_r <= '0;
            end
        end
    end

    // enables are the only software-writable state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_two_r <= '0; // [RQ7]
            en_one_r <= '0;
        end else if (done && pwrite) begin
            if (hit_two) begin
                en_two_r <= pef_pkg::enables_of(pwdata[15:0]); // [RQ7]
            end
            if (hit_one) begin
                en_one_r <= {pwdata[pef_pkg::ENB_FC_HF], pwdata[pef_pkg::ENB_RE_HF]}; // [RQ18]
            end
        end
    end

    // only bits seen by the read are cleared, and a present event wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_two_r <= '0;
        end else if (rd_two) begin
            flags_two_r <= (flags_two_r & ~pef_pkg::flags_of(prdata_r[15:0])) | ev_now; // [RQ19]
        end else begin
            flags_two_r <= flags_two_r | ev_now; // [RQ1] [RQ2] [RQ3] [RQ4] [RQ5] [RQ6]
        end
    end

    assign hf_now = {fc_cnt_r > pef_pkg::FC_HALF, re_cnt_r > pef_pkg::RE_HALF}; // [RQ11] [RQ16]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hf_r <= '0;
        end else if (rd_one) begin
            hf_r <= (hf_r & ~{prdata_r[pef_pkg::FLG_FC_HF], prdata_r[pef_pkg::FLG_RE_HF]}) | hf_now; // [RQ19]
        end else begin
            hf_r <= hf_r | hf_now; // [RQ18]
        end
    end

    // counters: a read subtracts what it returned, so counts arriving during it survive
    assign fc_inc = false_carrier; // [RQ9]
    assign re_inc = rx_invalid_symbol && rx_dv && rx_carrier && !mac_side_interface_loopback; // [RQ13] [RQ14]
    assign fc_base = rd_fc ? (fc_cnt_r - prdata_r[7:0]) : fc_cnt_r; // [RQ12]
    assign re_base = rd_re ? (re_cnt_r - prdata_r[15:0]) : re_cnt_r; // [RQ17]
    assign fc_next16 = pef_pkg::sat_inc({8'h00, fc_base}, fc_inc, {8'h00, pef_pkg::FC_MAX}); // [RQ10]
    assign re_next16 = pef_pkg::sat_inc(re_base, re_inc, pef_pkg::RE_MAX); // [RQ15]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fc_cnt_r <= '0;
        end else begin
            fc_cnt_r <= fc_next16[7:0]; // [RQ9] [RQ12]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            re_cnt_r <= '0;
        end else begin
            re_cnt_r <= re_next16; // [RQ13] [RQ17]
        end
    end

    // request lags the flags by one cycle to keep the output registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_req_r <= 1'b0;
        end else begin
            int_req_r <= (|(flags_two_r & en_two_r)) || (|(hf_r & en_one_r)); // [RQ20]
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign int_req = int_req_r;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_fc_read_quiet;
        (setup && !pwrite && hit_fc && !fc_inc) ##1 (rd_fc && !fc_inc);
    endsequence

    sequence s_re_read_quiet;
        (setup && !pwrite && hit_re && !re_inc) ##1 (rd_re && !re_inc);
    endsequence

    property p_uv_latch;
        level_r[pef_pkg::EV_UV] |=> flags_two_r[pef_pkg::EV_UV] ##1 (flags_two_r[pef_pkg::EV_UV] || $past(rd_two));
    endproperty
    a_uv_latch: assert property (p_uv_latch) else $error("undervoltage flag not latched"); // [RQ1]

    property p_ov_hold;
        flags_two_r[pef_pkg::EV_OV] && !rd_two |=> flags_two_r[pef_pkg::EV_OV];
    endproperty
    a_ov_hold: assert property (p_ov_hold) else $error("overvoltage flag dropped without read"); // [RQ2]

    property p_ot_read_word;
        setup && !pwrite && hit_two && flags_two_r[pef_pkg::EV_OT] |=> prdata[pef_pkg::FLG_OT] && pready;
    endproperty
    a_ot_read_word: assert property (p_ot_read_word) else $error("overtemperature flag not reported"); // [RQ3]

    property p_pol_change;
        $changed(level_r[pef_pkg::EV_POL]) |=> flags_two_r[pef_pkg::EV_POL];
    endproperty
    a_pol_change: assert property (p_pol_change) else $error("polarity change not flagged"); // [RQ5]

    property p_reserved_zero;
        // the receive error word uses every low bit, so beyond bits 31:16 only the false carrier upper byte and the second flags word gaps are checked
        pready && !pslverr |-> prdata[31:16] == 16'h0000
            && (!hit_two || (prdata[13:12] == 2'b00 && prdata[5:4] == 2'b00))
            && (!hit_fc || prdata[15:8] == 8'h00);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero"); // [RQ8]

    property p_fc_saturate;
        fc_cnt_r == pef_pkg::FC_MAX && !rd_fc |=> fc_cnt_r == pef_pkg::FC_MAX;
    endproperty
    a_fc_saturate: assert property (p_fc_saturate) else $error("false carrier counter wrapped"); // [RQ10]

    property p_fc_hf;
        fc_cnt_r == pef_pkg::FC_HALF && fc_inc && !rd_fc |=> ##1 hf_r[1];
    endproperty
    a_fc_hf: assert property (p_fc_hf) else $error("false carrier half-full not flagged"); // [RQ11]

    property p_fc_clear;
        s_fc_read_quiet |=> fc_cnt_r == 8'h00;
    endproperty
    a_fc_clear: assert property (p_fc_clear) else $error("false carrier count not cleared by read"); // [RQ12]

    property p_re_count;
        rx_invalid_symbol && rx_dv && rx_carrier && !mac_side_interface_loopback && !rd_re
            && re_cnt_r != pef_pkg::RE_MAX |=> re_cnt_r == $past(re_cnt_r) + 16'h0001;
    endproperty
    a_re_count: assert property (p_re_count) else $error("receive error not counted"); // [RQ13]

    property p_re_loopback;
        mac_side_interface_loopback && !rd_re |=> $stable(re_cnt_r);
    endproperty
    a_re_loopback: assert property (p_re_loopback) else $error("receive error counted in loopback"); // [RQ14]

    property p_re_clear;
        s_re_read_quiet |=> re_cnt_r == 16'h0000;
    endproperty
    a_re_clear: assert property (p_re_clear) else $error("receive error count not cleared by read"); // [RQ17]

    property p_int_req;
        (|(flags_two_r & en_two_r)) || (|(hf_r & en_one_r)) |=> int_req;
    endproperty
    a_int_req: assert property (p_int_req) else $error("interrupt not requested"); // [RQ20]

    property p_int_idle;
        !(|(flags_two_r & en_two_r)) && !(|(hf_r & en_one_r)) |=> !int_req;
    endproperty
    a_int_idle: assert property (p_int_idle) else $error("interrupt without enabled flag"); // [RQ7]

endmodule : pef_event_counters
`default_nettype wire

// >>> core/pef_pin_sync.sv
// three-stage pin synchroniser whose output follows once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pef_pin_sync #(
    parameter int unsigned WIDTH = 6
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // asynchronous levels in, settled levels out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level_r
);

    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;
    logic [WIDTH-1:0] differ;

    // stage one feeds stage two only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1_r <= '0;
            stage2_r <= '0;
            stage3_r <= '0;
        end else begin
            stage1_r <= async_in;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
        end
    end

    assign differ = stage2_r ^ stage3_r;

    // a bit moves only when two stages agree, filtering one-cycle glitches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_r <= '0;
        end else begin
            level_r <= (stage2_r & ~differ) | (level_r & differ);
        end
    end

endmodule : pef_pin_sync
`default_nettype wire

// >>> pkg/pef_pkg.sv
// shared constants, register map and field helpers of the event flag and error counter bank
package pef_pkg;

    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W = 16;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned EVT_W = 6;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_FLAGS_ONE = 8'h12;
    localparam logic [7:0] IDX_FLAGS_TWO = 8'h13;
    localparam logic [7:0] IDX_FC_CNT = 8'h14;
    localparam logic [7:0] IDX_RX_ERR_CNT = 8'h15;

    // event vector order inside the bank
    localparam int unsigned EV_UV = 5;
    localparam int unsigned EV_OV = 4;
    localparam int unsigned EV_OT = 3;
    localparam int unsigned EV_SLEEP = 2;
    localparam int unsigned EV_POL = 1;
    localparam int unsigned EV_JAB = 0;

    // flag and enable bit positions of the second flags register
    localparam int unsigned FLG_UV = 15;
    localparam int unsigned FLG_OV = 14;
    localparam int unsigned FLG_OT = 11;
    localparam int unsigned FLG_SLEEP = 10;
    localparam int unsigned FLG_POL = 9;
    localparam int unsigned FLG_JAB = 8;
    localparam int unsigned ENB_UV = 7;
    localparam int unsigned ENB_OV = 6;
    localparam int unsigned ENB_OT = 3;
    localparam int unsigned ENB_SLEEP = 2;
    localparam int unsigned ENB_POL = 1;
    localparam int unsigned ENB_JAB = 0;

    // half-full flags and enables of the first flags register
    localparam int unsigned FLG_FC_HF = 9;
    localparam int unsigned FLG_RE_HF = 8;
    localparam int unsigned ENB_FC_HF = 1;
    localparam int unsigned ENB_RE_HF = 0;

    // counter limits
    localparam logic [7:0] FC_MAX = 8'hFF;
    localparam logic [7:0] FC_HALF = 8'h7F;
    localparam logic [15:0] RE_MAX = 16'hFFFF;
    localparam logic [15:0] RE_HALF = 16'h7FFF;
    localparam logic [15:0] REG_RESET = 16'h0000;

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        return {idx[5:0], 2'b00};
    endfunction : byte_addr

    function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic inc, input logic [15:0] lim);
        if (inc && (v != lim)) begin
            return v + 16'h0001;
        end
        return v;
    endfunction : sat_inc

    function automatic logic [5:0] flags_of(input logic [15:0] w);
        return {w[FLG_UV], w[FLG_OV], w[FLG_OT], w[FLG_SLEEP], w[FLG_POL], w[FLG_JAB]};
    endfunction : flags_of

    function automatic logic [5:0] enables_of(input logic [15:0] w);
        return {w[ENB_UV], w[ENB_OV], w[ENB_OT], w[ENB_SLEEP], w[ENB_POL], w[ENB_JAB]};
    endfunction : enables_of

endpackage : pef_pkg

// >>> verif/pef_event_counters_tb.sv
// self-checking bench of the event flag and error counter bank
`timescale 1ns/10ps
`default_nettype none
module pef_event_counters_tb;
    localparam logic [7:0] A_F1 = 8'h48;
    localparam logic [7:0] A_F2 = 8'h4C;
    localparam logic [7:0] A_FC = 8'h50;
    localparam logic [7:0] A_RE = 8'h54;
    localparam logic [7:0] A_BAD = 8'h60;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] evt;
    logic false_carrier;
    logic rx_carrier;
    logic rx_dv;
    logic rx_inv;
    logic lpbk;
    logic int_req;
    logic [31:0] rd;
    logic err;
    int n_mismatch;
    int num_checks;
    int unsigned flg[6] = '{15, 14, 11, 10, 9, 8};
    int unsigned enb[6] = '{7, 6, 3, 2, 1, 0};

    pef_host_model u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    pef_event_counters u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .undervoltage(evt[5]), .overvoltage(evt[4]), .overtemperature(evt[3]),
        .sleep_event(evt[2]), .rx_polarity(evt[1]), .jabber(evt[0]), .false_carrier(false_carrier),
        .rx_carrier(rx_carrier), .rx_dv(rx_dv), .rx_invalid_symbol(rx_inv),
        .mac_side_interface_loopback(lpbk), .int_req(int_req));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
        u_host.xfer(1'b0, a, 32'h0000_0000, rd, err);
        chk(rd, exp, msg);
        chk({31'h0, err}, 32'h0000_0000, "unexpected slave error");
    endtask : rd_chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, rd, err);
    endtask : wr

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    task automatic fc_pulse(input int n);
        @(posedge pclk);
        false_carrier <= 1'b1;
        cyc(n);
        false_carrier <= 1'b0;
    endtask : fc_pulse

    task automatic re_pulse(input int n, input logic cr, input logic dv, input logic lb);
        @(posedge pclk);
        rx_carrier <= cr;
        rx_dv <= dv;
        rx_inv <= 1'b1;
        lpbk <= lb;
        cyc(n);
        rx_carrier <= 1'b0;
        rx_dv <= 1'b0;
        rx_inv <= 1'b0;
        lpbk <= 1'b0;
    endtask : re_pulse

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // the longest test saturates the 16-bit counter, about 66k cycles
    initial begin
        repeat (80000) @(posedge pclk);
        n_mismatch++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        finish_test();
    end

    initial begin
        presetn = 1'b0;
        evt = 6'h00;
        false_carrier = 1'b0;
        rx_carrier = 1'b0;
        rx_dv = 1'b0;
        rx_inv = 1'b0;
        lpbk = 1'b0;
        cyc(2);
        presetn <= 1'b1;
        rd_chk(A_F1, 32'h0000_0000, "first flags reset");
        rd_chk(A_F2, 32'h0000_0000, "second flags reset");
        rd_chk(A_FC, 32'h0000_0000, "false carrier reset");
        rd_chk(A_RE, 32'h0000_0000, "receive error reset");
        u_host.xfer(1'b0, A_BAD, 32'h0000_0000, rd, err);
        chk(rd, 32'h0000_0000, "unmapped data");
        chk({31'h0, err}, 32'h0000_0001, "unmapped error");
        wr(A_FC, 32'h0000_00ab);
        rd_chk(A_FC, 32'h0000_0000, "counter not writable");
        wr(A_F2, 32'hffff_ffff);
        rd_chk(A_F2, 32'h0000_00cf, "enables only writable");
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            wr(A_F2, 32'h0000_0000);
            evt[5 - i] <= 1'b1;
            cyc(4);
            evt[5 - i] <= 1'b0;
            cyc(10);
            chk({31'h0, int_req}, 32'h0000_0000, "masked event");
            wr(A_F2, 32'h0000_0001 << enb[i]);
            cyc(3);
            chk({31'h0, int_req}, 32'h0000_0001, "enabled pending event");
            rd_chk(A_F2, (32'h0000_0001 << flg[i]) | (32'h0000_0001 << enb[i]), "flag latched");
            rd_chk(A_F2, 32'h0000_0001 << enb[i], "flag cleared by read");
            cyc(3);
            chk({31'h0, int_req}, 32'h0000_0000, "request dropped");
        end
        wr(A_F2, 32'h0000_0000);
        evt[3] <= 1'b1;
        cyc(8);
        rd_chk(A_F2, 32'h0000_0800, "level event");
        rd_chk(A_F2, 32'h0000_0800, "present event survives read");
        evt[3] <= 1'b0;
        cyc(8);
        rd_chk(A_F2, 32'h0000_0800, "held after event ends");
        rd_chk(A_F2, 32'h0000_0000, "cleared once gone");
        $display("test events done");
        fc_pulse(5);
        cyc(2);
        rd_chk(A_FC, 32'h0000_0005, "false carrier count");
        wr(A_F1, 32'h0000_0003);
        fc_pulse(127);
        cyc(4);
        chk({31'h0, int_req}, 32'h0000_0000, "no request at half");
        rd_chk(A_F1, 32'h0000_0003, "no flag at half");
        fc_pulse(1);
        cyc(4);
        chk({31'h0, int_req}, 32'h0000_0001, "request above half");
        rd_chk(A_F1, 32'h0000_0203, "false carrier half-full");
        fc_pulse(144);
        cyc(2);
        rd_chk(A_FC, 32'h0000_00ff, "false carrier saturates");
        rd_chk(A_FC, 32'h0000_0000, "false carrier cleared");
        rd_chk(A_F1, 32'h0000_0203, "half-full still latched");
        rd_chk(A_F1, 32'h0000_0003, "half-full cleared");
        $display("test false carrier done");
        re_pulse(3, 1'b1, 1'b1, 1'b0);
        re_pulse(2, 1'b1, 1'b0, 1'b0);
        re_pulse(2, 1'b0, 1'b1, 1'b0);
        re_pulse(2, 1'b1, 1'b1, 1'b1);
        cyc(2);
        rd_chk(A_RE, 32'h0000_0003, "qualified errors only");
        re_pulse(32767, 1'b1, 1'b1, 1'b0);
        cyc(4);
        chk({31'h0, int_req}, 32'h0000_0000, "no request at half");
        rd_chk(A_F1, 32'h0000_0003, "no flag at half");
        re_pulse(1, 1'b1, 1'b1, 1'b0);
        cyc(4);
        chk({31'h0, int_req}, 32'h0000_0001, "request above half");
        rd_chk(A_F1, 32'h0000_0103, "receive error half-full");
        re_pulse(32768, 1'b1, 1'b1, 1'b0);
        cyc(2);
        rd_chk(A_RE, 32'h0000_ffff, "receive error saturates");
        rd_chk(A_RE, 32'h0000_0000, "receive error cleared");
        $display("test receive error done");
        finish_test();
    end
endmodule : pef_event_counters_tb
`default_nettype wire

// >>> verif/pef_host_model.sv
// apb master standing in for the station management host
`timescale 1ns/10ps
`default_nettype none
module pef_host_model (
    // clock
    input wire logic pclk,
    // apb master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [pef_pkg::ADDR_W-1:0] paddr,
    output logic [pef_pkg::DATA_W-1:0] pwdata,
    input wire logic [pef_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end

    // one whole transfer; a read clears the flags and counts it returns, so callers keep the value
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle count assumed; only the bench watchdog ends a stuck wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines show no stale value, so a slave sampling late is caught
        paddr <= ~a;
        pwdata <= ~wd;
    endtask : xfer
endmodule : pef_host_model
`default_nettype wire
